// File: hw/bms_pkg.sv
// Shared constants and types for the battery measurement scheduler.
package bms_pkg;
   // Core clock period and measurement period.
   localparam int CLK_PERIOD_NS = 10;
   localparam int PERIOD_MS = 500;
   localparam int PERIOD_CYCLES = PERIOD_MS * 1000000 / CLK_PERIOD_NS;
   // Auto-zero interval and temperature hold after a switch press, in periods.
   localparam int HOLD_S = 30;
   localparam int HOLD_PERIODS = HOLD_S * 1000 / PERIOD_MS;
   localparam logic [7:0] HOLD_LAST = 8'(HOLD_PERIODS - 1);
   localparam logic [7:0] HOLD_LOAD = 8'(HOLD_PERIODS);
   // Data width and the supported cell count.
   localparam int DW = 16;
   localparam int NUM_CELLS = 4;
   // Scale shifts: 2048 for voltage and temperature, 16384 for current.
   localparam logic [3:0] VOLT_SHIFT = 4'h0_00B;
   localparam logic [3:0] CURR_SHIFT = 4'h0_00E;
   // Divisor of the path resistance compensation.
   localparam logic signed [32:0] RES_DIV = 33'sh0_FFFF;
   // Least reduced-rate interval and the consecutive count for mode moves.
   localparam logic [15:0] MIN_INTERVAL = 16'h0002;
   localparam logic [1:0] CONSEC = 2'h2;
   // Converter channel codes.
   localparam logic [2:0] CH_CURRENT = 3'h0;
   localparam logic [2:0] CH_ZERO = 3'h1;
   localparam logic [2:0] CH_CELL = 3'h2;
   localparam logic [2:0] CH_TEMP_INT = 3'h3;
   localparam logic [2:0] CH_TEMP_EXT = 3'h4;
   // Thermistor voltage to temperature table, in 0.1 kelvin steps.
   localparam logic [15:0] NTC_LUT [8] = '{16'h0A6A, 16'h0ACE, 16'h0B14, 16'h0B4D,
      16'h0B82, 16'h0BB8, 16'h0BF2, 16'h0C40};
   // Power states.
   typedef enum logic [2:0] {
      MODE_RUN = 3'h1, MODE_SAMPLE = 3'h2, MODE_SLEEP = 3'h4
   } bms_mode_t;
   // Conversion sequencer states.
   typedef enum logic [5:0] {
      SQ_IDLE = 6'h01, SQ_CURR = 6'h02, SQ_CELL = 6'h04,
      SQ_TINT = 6'h08, SQ_TEXT = 6'h10, SQ_CALC = 6'h20
   } bms_seq_t;
endpackage

// File: hw/bms_corr.sv
// Offset and gain correction of one raw converter result.
`timescale 1ns/1ps
`default_nettype none
module bms_corr import bms_pkg::*; (
   // Raw result and calibration pair.
   input wire logic signed [DW-1:0] raw_in,
   input wire logic signed [DW-1:0] offset_in,
   input wire logic [DW-1:0] gain_in,
   input wire logic [3:0] shift_in,
   // Corrected result.
   output logic signed [DW-1:0] corr_out
);
   // One extra bit keeps the difference from wrapping.
   logic signed [DW:0] diff;
   logic signed [2*DW+1:0] prod;
   logic signed [2*DW+1:0] scaled;
   assign diff = (DW+1)'(raw_in) - (DW+1)'(offset_in);
   assign prod = diff * $signed({1'b0, gain_in});
   // Arithmetic shift keeps negative currents negative.
   assign scaled = prod >>> shift_in;
   // The caller sees the low word; calibration keeps results in range.
   assign corr_out = scaled[DW-1:0];
endmodule
`default_nettype wire

// File: hw/bms_sched.sv
// Measurement scheduler: sequencing, correction and power-state control.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Convert only in periods with converter active.
// - Exactly one cell conversion per measuring period.
// - Up to four cells, input one is top.
// - Cell and pack conversions use 11-bit mode.
// - Pack voltage adds current times resistance compensation.
// - Pack voltage: offset, gain, divide by 2048.
// - Cells share offset, gain picked per cell.
// - Temperature converted in 11-bit mode, internal/external.
// - Separate calibration pairs per temperature source.
// - Thermistor voltage mapped through lookup table.
// - Hold temperature readings 30 s after switch.
// - Three power states set the measuring rate.
// - Threshold is limit times gain over 16384.
// - Two readings above threshold enter full rate.
// - Two readings below threshold go to reduced.
// - Full rate measures current, voltage, temperature each period.
// - Reduced rate exits to full rate or sleep.
// - Reduced rate measures once per interval count.
// - Interval count never below two.
// - Current: minus offsets, times gain, over 16384.
// - Auto-zero every 30 s replaces current conversion.
// - Currents inside the zero band read zero.
module bms_sched import bms_pkg::*; #(
   parameter int PERIOD_CYC = PERIOD_CYCLES
) (
   // Clock and synchronous reset.
   input wire logic core_clk_in,
   input wire logic rst_in,
   // Converter handshake.
   output logic conv_start_out,
   output logic [2:0] conv_chan_out,
   output logic [1:0] conv_cell_out,
   output logic conv_res11_out,
   input wire logic conv_done_in,
   input wire logic signed [DW-1:0] conv_data_in,
   // Configuration.
   input wire logic [1:0] cell_count_in,
   input wire logic ext_temp_en_in,
   input wire logic zero_en_in,
   input wire logic [DW-1:0] run_threshold_limit_in,
   input wire logic [DW-1:0] reduced_rate_interval_in,
   input wire logic [DW-1:0] path_resistance_comp_in,
   // Calibration constants.
   input wire logic signed [DW-1:0] pack_voltage_offset_in,
   input wire logic [DW-1:0] pack_voltage_gain_in,
   input wire logic signed [DW-1:0] cell_voltage_offset_in,
   input wire logic [NUM_CELLS-1:0][DW-1:0] cell_voltage_gain_in,
   input wire logic signed [DW-1:0] internal_temp_offset_in,
   input wire logic [DW-1:0] internal_temp_gain_in,
   input wire logic signed [DW-1:0] external_temp_offset_in,
   input wire logic [DW-1:0] external_temp_gain_in,
   input wire logic signed [DW-1:0] current_offset_in,
   input wire logic [DW-1:0] current_gain_in,
   input wire logic [DW-1:0] zero_current_band_in,
   // Display switch pin and power-state requests.
   input wire logic switch_in,
   input wire logic sleep_req_in,
   input wire logic wake_in,
   // Status.
   output logic [2:0] mode_out,
   output logic period_tick_out,
   output logic meas_active_out,
   output logic temp_hold_out,
   output logic signed [DW-1:0] current_ma_out,
   output logic signed [DW-1:0] pack_mv_out,
   output logic [NUM_CELLS-1:0][DW-1:0] cell_mv_out,
   output logic signed [DW-1:0] temp_int_out,
   output logic [DW-1:0] temp_ext_out,
   output logic signed [DW-1:0] zero_offset_value_out
);
   bms_seq_t seq_q;
   bms_mode_t mode_q;
   logic [31:0] per_cnt_q; // Cycle counter of the measurement period.
   logic per_tick; // One cycle at the end of each period.
   logic [15:0] samp_cnt_q; // Reduced-rate period counter.
   logic [15:0] interval_eff; // Interval count after the minimum clamp.
   logic meas_now; // This period takes measurements.
   logic meas_per_q; // A measuring period is in progress.
   logic zero_run_q; // The current slot of this period is an auto-zero.
   logic [7:0] zero_per_q; // Periods since the last auto-zero.
   logic zero_due;
   logic [2:0] sw_q; // Switch pin synchroniser.
   logic sw_lvl_q; // Filtered switch level.
   logic [7:0] hold_cnt_q; // Periods left in the temperature hold.
   logic temp_hold;
   logic start_q;
   logic [2:0] chan_q;
   logic [1:0] cell_idx_q;
   logic [1:0] consec_q; // Consecutive readings past the threshold.
   logic signed [DW-1:0] current_q, pack_q, temp_int_q, zero_val_q;
   logic [DW-1:0] temp_ext_q;
   logic [NUM_CELLS-1:0][DW-1:0] cell_q;
   logic signed [DW-1:0] corr_off, corr_val, pack_corr;
   logic [DW-1:0] corr_gain;
   logic [3:0] corr_shift;
   logic [DW-1:0] cur_abs, raw_abs;
   logic [31:0] thr;
   logic signed [32:0] comp_prod, comp;
   logic signed [DW-1:0] pack_sum;

   // The period counter runs in every mode so servicing keeps its rate.
   always_ff @(posedge core_clk_in) begin
      if (rst_in || per_cnt_q == 32'(PERIOD_CYC - 1)) begin
         per_cnt_q <= 32'h0000_0000;
      end else begin
         per_cnt_q <= per_cnt_q + 32'h0000_0001;
      end
   end
   assign per_tick = (per_cnt_q == 32'(PERIOD_CYC - 1));

   // A too small interval would let the converter run every period.
   assign interval_eff = (reduced_rate_interval_in < MIN_INTERVAL) ? MIN_INTERVAL
      : reduced_rate_interval_in;
   // Sleep never measures; reduced rate measures on a zero count only.
   assign meas_now = (mode_q == MODE_RUN) ||
      (mode_q == MODE_SAMPLE && samp_cnt_q == 16'h0000);

   // Reduced-rate counter restarts from zero on every entry.
   always_ff @(posedge core_clk_in) begin
      if (rst_in || mode_q != MODE_SAMPLE) begin
         samp_cnt_q <= 16'h0000;
      end else if (per_tick) begin
         samp_cnt_q <= (samp_cnt_q >= interval_eff - 16'h0001) ? 16'h0000
            : samp_cnt_q + 16'h0001;
      end
   end

   // Auto-zero timer saturates so a late measuring period still zeroes.
   always_ff @(posedge core_clk_in) begin
      if (rst_in || !zero_en_in) begin
         zero_per_q <= 8'h00;
      end else if (seq_q == SQ_IDLE && per_tick && meas_now && zero_due) begin
         zero_per_q <= 8'h00;
      end else if (per_tick && !zero_due) begin
         zero_per_q <= zero_per_q + 8'h01;
      end
   end
   assign zero_due = zero_en_in && (zero_per_q == HOLD_LAST);

   // The switch pin is asynchronous; only the second and third stages are compared.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sw_q <= 3'h0;
         sw_lvl_q <= 1'b0;
      end else begin
         sw_q <= {sw_q[1:0], switch_in};
         if (sw_q[1] == sw_q[2]) begin
            sw_lvl_q <= sw_q[2];
         end
      end
   end

   // A press reloads the hold so LED heating never reaches the readings.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         hold_cnt_q <= 8'h00;
      end else if (sw_q[1] == sw_q[2] && sw_q[2] && !sw_lvl_q) begin
         hold_cnt_q <= HOLD_LOAD;
      end else if (per_tick && hold_cnt_q != 8'h00) begin
         hold_cnt_q <= hold_cnt_q - 8'h01;
      end
   end
   assign temp_hold = (hold_cnt_q != 8'h00);

   // Conversion sequencer: current, one cell, then the temperatures.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         seq_q <= SQ_IDLE;
         start_q <= 1'b0;
         chan_q <= CH_CURRENT;
         meas_per_q <= 1'b0;
         zero_run_q <= 1'b0;
      end else begin
         start_q <= 1'b0;
         case (seq_q)
            SQ_IDLE: begin
               // A period that overruns simply skips the next start.
               if (per_tick && meas_now) begin
                  meas_per_q <= 1'b1;
                  zero_run_q <= zero_due;
                  chan_q <= zero_due ? CH_ZERO : CH_CURRENT;
                  start_q <= 1'b1;
                  seq_q <= SQ_CURR;
               end
            end
            SQ_CURR: begin
               if (conv_done_in) begin
                  chan_q <= CH_CELL;
                  start_q <= 1'b1;
                  seq_q <= SQ_CELL;
               end
            end
            SQ_CELL: begin
               if (conv_done_in && temp_hold) begin
                  seq_q <= SQ_CALC;
               end else if (conv_done_in) begin
                  chan_q <= CH_TEMP_INT;
                  start_q <= 1'b1;
                  seq_q <= SQ_TINT;
               end
            end
            SQ_TINT: begin
               if (conv_done_in && ext_temp_en_in && !temp_hold) begin
                  chan_q <= CH_TEMP_EXT;
                  start_q <= 1'b1;
                  seq_q <= SQ_TEXT;
               end else if (conv_done_in) begin
                  seq_q <= SQ_CALC;
               end
            end
            SQ_TEXT: begin
               if (conv_done_in) begin
                  seq_q <= SQ_CALC;
               end
            end
            SQ_CALC: begin
               meas_per_q <= 1'b0;
               seq_q <= SQ_IDLE;
            end
            default: begin
               seq_q <= SQ_IDLE;
            end
         endcase
      end
   end

   // Calibration pair follows the conversion in flight.
   always_comb begin
      corr_off = '0;
      corr_gain = '0;
      corr_shift = VOLT_SHIFT;
      case (seq_q)
         SQ_CURR: begin
            corr_off = DW'(current_offset_in + zero_val_q);
            corr_gain = current_gain_in;
            corr_shift = CURR_SHIFT;
         end
         SQ_CELL: begin
            corr_off = cell_voltage_offset_in;
            corr_gain = cell_voltage_gain_in[cell_idx_q];
         end
         SQ_TINT: begin
            corr_off = internal_temp_offset_in;
            corr_gain = internal_temp_gain_in;
         end
         SQ_TEXT: begin
            corr_off = external_temp_offset_in;
            corr_gain = external_temp_gain_in;
         end
         default: begin
            corr_off = '0;
         end
      endcase
   end

   // Shared correction for current, cells and temperatures.
   bms_corr u_corr (
      .raw_in(conv_data_in),
      .offset_in(corr_off),
      .gain_in(corr_gain),
      .shift_in(corr_shift),
      .corr_out(corr_val)
   );

   // Pack constants applied to the top cell input.
   bms_corr u_pack (
      .raw_in(conv_data_in),
      .offset_in(pack_voltage_offset_in),
      .gain_in(pack_voltage_gain_in),
      .shift_in(VOLT_SHIFT),
      .corr_out(pack_corr)
   );

   // Path drop uses current_q, converted earlier in the same period unless that slot was an auto-zero.
   assign comp_prod = current_q * $signed({1'b0, path_resistance_comp_in});
   assign comp = comp_prod / RES_DIV;
   assign pack_sum = pack_corr + comp[DW-1:0];
   assign raw_abs = corr_val[DW-1] ? DW'(-corr_val) : corr_val;

   // Results are captured on the converter's done strobe.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         current_q <= '0;
         zero_val_q <= '0;
         pack_q <= '0;
         cell_q <= '0;
         temp_int_q <= '0;
         temp_ext_q <= '0;
      end else if (conv_done_in) begin
         case (seq_q)
            SQ_CURR: begin
               if (zero_run_q) begin
                  zero_val_q <= conv_data_in;
               end else if (raw_abs < zero_current_band_in) begin
                  current_q <= '0;
               end else begin
                  current_q <= corr_val;
               end
            end
            SQ_CELL: begin
               cell_q[cell_idx_q] <= corr_val;
               if (cell_idx_q == 2'h0) begin
                  pack_q <= pack_sum;
               end
            end
            SQ_TINT: begin
               temp_int_q <= corr_val;
            end
            SQ_TEXT: begin
               temp_ext_q <= NTC_LUT[corr_val[10:8]];
            end
            default: begin
               temp_ext_q <= temp_ext_q;
            end
         endcase
      end
   end

   // Next cell after each cell conversion, back to the top cell at the end.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cell_idx_q <= 2'h0;
      end else if (seq_q == SQ_CELL && conv_done_in) begin
         cell_idx_q <= (cell_idx_q >= cell_count_in) ? 2'h0 : cell_idx_q + 2'h1;
      end
   end

   // Threshold in mA from the limit and the current gain.
   assign thr = (32'(run_threshold_limit_in) * 32'(current_gain_in)) >> CURR_SHIFT;
   assign cur_abs = current_q[DW-1] ? DW'(-current_q) : current_q;

   // Power state moves; an auto-zero period brings no new reading to count.
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         mode_q <= MODE_RUN;
         consec_q <= 2'h0;
      end else begin
         case (mode_q)
            MODE_RUN: begin
               if (seq_q == SQ_CALC && !zero_run_q) begin
                  if (32'(cur_abs) < thr) begin
                     consec_q <= consec_q + 2'h1;
                     if (consec_q + 2'h1 == CONSEC) begin
                        mode_q <= MODE_SAMPLE;
                        consec_q <= 2'h0;
                     end
                  end else begin
                     consec_q <= 2'h0;
                  end
               end
            end
            MODE_SAMPLE: begin
               if (sleep_req_in && seq_q == SQ_IDLE && !per_tick) begin
                  mode_q <= MODE_SLEEP;
                  consec_q <= 2'h0;
               end else if (seq_q == SQ_CALC && !zero_run_q) begin
                  if (32'(cur_abs) > thr) begin
                     consec_q <= consec_q + 2'h1;
                     if (consec_q + 2'h1 == CONSEC) begin
                        mode_q <= MODE_RUN;
                        consec_q <= 2'h0;
                     end
                  end else begin
                     consec_q <= 2'h0;
                  end
               end
            end
            MODE_SLEEP: begin
               // Wake-up sources are decided outside this block.
               if (wake_in) begin
                  mode_q <= MODE_RUN;
               end
            end
            default: begin
               mode_q <= MODE_RUN;
            end
         endcase
      end
   end

   // Converter strobes and status outputs.
   assign conv_start_out = start_q;
   assign conv_chan_out = chan_q;
   assign conv_cell_out = cell_idx_q;
   assign conv_res11_out = (chan_q != CH_CURRENT) && (chan_q != CH_ZERO);
   assign mode_out = mode_q;
   assign period_tick_out = per_tick;
   assign meas_active_out = meas_per_q;
   assign temp_hold_out = temp_hold;
   assign current_ma_out = current_q;
   assign pack_mv_out = pack_q;
   assign cell_mv_out = cell_q;
   assign temp_int_out = temp_int_q;
   assign temp_ext_out = temp_ext_q;
   assign zero_offset_value_out = zero_val_q;

   // Cell starts seen in the current measuring period.
   logic [1:0] cell_starts_q;
   always_ff @(posedge core_clk_in) begin
      if (rst_in || seq_q == SQ_IDLE) begin
         cell_starts_q <= 2'h0;
      end else if (start_q && chan_q == CH_CELL && cell_starts_q != 2'h3) begin
         cell_starts_q <= cell_starts_q + 2'h1;
      end
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   property p_start_in_meas;
      conv_start_out |-> meas_per_q && mode_q != MODE_SLEEP;
   endproperty
   a_start_in_meas: assert property (p_start_in_meas) else $error("start outside period");
   property p_one_cell;
      cell_starts_q <= 2'h1;
   endproperty
   a_one_cell: assert property (p_one_cell) else $error("two cell conversions");
   property p_cell_wrap;
      (seq_q == SQ_CELL && conv_done_in) |=> cell_idx_q ==
         (($past(cell_idx_q) >= $past(cell_count_in)) ? 2'h0 : $past(cell_idx_q) + 2'h1);
   endproperty
   a_cell_wrap: assert property (p_cell_wrap) else $error("cell index wrong");
   property p_res11;
      conv_start_out && (conv_chan_out == CH_CELL || conv_chan_out == CH_TEMP_INT)
         |-> conv_res11_out;
   endproperty
   a_res11: assert property (p_res11) else $error("not 11-bit mode");
   property p_interval;
      mode_q == MODE_SAMPLE |-> samp_cnt_q < interval_eff && interval_eff >= MIN_INTERVAL;
   endproperty
   a_interval: assert property (p_interval) else $error("interval count too small");
   property p_cnt_idle;
      $past(mode_q) != MODE_SAMPLE |-> samp_cnt_q == 16'h0000;
   endproperty
   a_cnt_idle: assert property (p_cnt_idle) else $error("counter not zero");
   property p_run_exit;
      $past(mode_q) == MODE_RUN && mode_q != MODE_RUN |-> mode_q == MODE_SAMPLE;
   endproperty
   a_run_exit: assert property (p_run_exit) else $error("run left to wrong mode");
   property p_temp_hold;
      conv_start_out && (conv_chan_out == CH_TEMP_INT || conv_chan_out == CH_TEMP_EXT)
         |-> $past(hold_cnt_q) == 8'h00;
   endproperty
   a_temp_hold: assert property (p_temp_hold) else $error("temperature during hold");
   property p_run_meas;
      (mode_q == MODE_RUN && seq_q == SQ_IDLE && per_tick) |=> conv_start_out ##1 seq_q == SQ_CURR;
   endproperty
   a_run_meas: assert property (p_run_meas) else $error("run period not measured");
   property p_sleep_quiet;
      mode_q == MODE_SLEEP && seq_q == SQ_IDLE |=> !conv_start_out;
   endproperty
   a_sleep_quiet: assert property (p_sleep_quiet) else $error("sleep conversion");

   c_to_sample: cover property (mode_q == MODE_RUN ##1 mode_q == MODE_SAMPLE);
   c_zero_run: cover property (conv_start_out && conv_chan_out == CH_ZERO);
   c_ext_temp: cover property (conv_start_out && conv_chan_out == CH_TEMP_EXT);
   c_cell_wrap: cover property (seq_q == SQ_CELL && conv_done_in && cell_idx_q == 2'h3);
endmodule
`default_nettype wire

// File: verif/bms_adc_model.sv
// Behavioural converter that answers the scheduler's start pulses.
`timescale 1ns/1ps
`default_nettype none
module bms_adc_model import bms_pkg::*; (
   // Clock and reset.
   input wire logic clk_in,
   input wire logic rst_in,
   // Start request and raw value per channel.
   input wire logic start_in,
   input wire logic [2:0] chan_in,
   input wire logic [3:0] lat_in,
   input wire logic [4:0][DW-1:0] raw_in,
   // Result strobe and data.
   output logic done_out,
   output logic [DW-1:0] data_out
);
   logic [3:0] cnt_q;
   logic busy_q;
   logic [2:0] ch_q;
   // Data toggles while no result is valid, so a badly timed sample cannot pass.
   always_ff @(posedge clk_in) begin
      done_out <= 1'b0;
      data_out <= ~data_out;
      if (rst_in) begin
         busy_q <= 1'b0;
         data_out <= 16'h0000;
      end else if (start_in) begin
         busy_q <= 1'b1;
         cnt_q <= lat_in;
         ch_q <= chan_in;
      end else if (busy_q && cnt_q == 4'h0) begin
         busy_q <= 1'b0;
         done_out <= 1'b1;
         data_out <= raw_in[ch_q];
      end else if (busy_q) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end
endmodule
`default_nettype wire

// File: verif/tb_bms_sched.sv
// Self-checking bench for the measurement scheduler.
`timescale 1ns/1ps
`default_nettype none
module tb_bms_sched import bms_pkg::*;;
   logic core_clk_in = 0, rst_in = 1, conv_done_in, switch_in = 0, sleep_req_in = 0, wake_in = 0;
   logic [15:0] conv_data_in;
   logic [1:0] cell_count_in = 2'h1;
   logic ext_temp_en_in = 1, zero_en_in = 0;
   logic [15:0] run_threshold_limit_in = 16'h0064, reduced_rate_interval_in = 16'h0000;
   logic [15:0] path_resistance_comp_in = 16'h3333, pack_voltage_offset_in = 16'h0000;
   logic [15:0] pack_voltage_gain_in = 16'h0800, cell_voltage_offset_in = 16'h000A;
   logic [3:0][15:0] cell_voltage_gain_in = {16'h0800, 16'h0800, 16'h1000, 16'h0800};
   logic [15:0] internal_temp_offset_in = 16'h0064, internal_temp_gain_in = 16'h0800;
   logic [15:0] external_temp_offset_in = 16'h0000, external_temp_gain_in = 16'h1000;
   logic [15:0] current_offset_in = 16'h0000, current_gain_in = 16'h4000;
   logic [15:0] zero_current_band_in = 16'h0005;
   logic conv_start_out, conv_res11_out, period_tick_out, meas_active_out, temp_hold_out;
   logic [2:0] conv_chan_out, mode_out;
   logic [1:0] conv_cell_out;
   logic [15:0] current_ma_out, pack_mv_out, temp_int_out, temp_ext_out, zero_offset_value_out;
   logic [3:0][15:0] cell_mv_out;
   // Raw converter values: current, zero, cell, internal and external temperature.
   logic [4:0][15:0] raw = {16'h0300, 16'h012C, 16'h03E8, 16'h0064, 16'h01F4};
   logic [2:0] seq [4] = '{CH_CURRENT, CH_CELL, CH_TEMP_INT, CH_TEMP_EXT};
   logic [2:0] chq [$];
   logic [1:0] clq [$];
   int err_count = 0, cmp_count = 0;
   always #5 core_clk_in = ~core_clk_in;
   bms_sched #(.PERIOD_CYC(40)) i_bms_sched (.core_clk_in, .rst_in, .conv_start_out,
      .conv_chan_out, .conv_cell_out, .conv_res11_out, .conv_done_in, .conv_data_in,
      .cell_count_in, .ext_temp_en_in, .zero_en_in, .run_threshold_limit_in,
      .reduced_rate_interval_in, .path_resistance_comp_in, .pack_voltage_offset_in,
      .pack_voltage_gain_in, .cell_voltage_offset_in, .cell_voltage_gain_in,
      .internal_temp_offset_in, .internal_temp_gain_in, .external_temp_offset_in,
      .external_temp_gain_in, .current_offset_in, .current_gain_in, .zero_current_band_in,
      .switch_in, .sleep_req_in, .wake_in, .mode_out, .period_tick_out, .meas_active_out,
      .temp_hold_out, .current_ma_out, .pack_mv_out, .cell_mv_out, .temp_int_out,
      .temp_ext_out, .zero_offset_value_out);
   // A slow answer four cycles after each start keeps the sequencer waiting on every conversion.
   bms_adc_model i_bms_adc_model (.clk_in(core_clk_in), .rst_in(rst_in),
      .start_in(conv_start_out), .chan_in(conv_chan_out), .lat_in(4'h2), .raw_in(raw),
      .done_out(conv_done_in), .data_out(conv_data_in));
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask
   task automatic wrap_up;
      if (err_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Waits for n period ticks, each followed by the end of its measuring window.
   task automatic tick(input int n);
      int k;
      repeat (n) begin
         k = 0;
         do begin
            @(posedge core_clk_in);
            k++;
         end while (period_tick_out !== 1'b1 && k < 200);
         repeat (3) @(posedge core_clk_in);
         while (meas_active_out !== 1'b0 && k < 200) begin
            @(posedge core_clk_in);
            k++;
         end
         if (k >= 200) begin
            err_count++;
            wrap_up();
         end
      end
      #1;
   endtask
   task automatic pulse(input int which);
      @(posedge core_clk_in);
      #1 if (which == 0) sleep_req_in = 1; else wake_in = 1;
      @(posedge core_clk_in);
      #1 sleep_req_in = 0;
      wake_in = 0;
   endtask
   // Record every start; the resolution setting must follow the channel.
   always @(posedge core_clk_in) begin
      if (conv_start_out === 1'b1) begin
         chq.push_back(conv_chan_out);
         if (conv_chan_out == CH_CELL) clq.push_back(conv_cell_out);
         chk(16'(conv_res11_out), 16'(conv_chan_out >= CH_CELL));
      end
   end
   initial begin
      int n;
      n = 0;
      repeat (10) @(posedge core_clk_in);
      #1 rst_in = 0;
      chk(16'(mode_out), 16'(MODE_RUN));
      chk(current_ma_out, 16'h0000);
      tick(3);
      chk(16'(chq.size()), 16'h000C);
      foreach (chq[i]) chk(16'(chq[i]), 16'(seq[i % 4]));
      foreach (clq[i]) chk(16'(clq[i]), 16'(i % 2));
      chk(current_ma_out, 16'h01F4);
      chk(cell_mv_out[0], 16'h03DE);
      chk(cell_mv_out[1], 16'h07BC);
      chk(pack_mv_out, 16'h044C);
      chk(temp_int_out, 16'h00C8);
      chk(temp_ext_out, NTC_LUT[6]);
      raw[0] = 16'h0003;
      tick(1);
      chk(current_ma_out, 16'h0000);
      chk(16'(mode_out), 16'(MODE_RUN));
      tick(1);
      chk(16'(mode_out), 16'(MODE_SAMPLE));
      chq.delete();
      tick(4);
      chk(16'(chq.size()), 16'h0008);
      pulse(0);
      chk(16'(mode_out), 16'(MODE_SLEEP));
      chq.delete();
      tick(2);
      chk(16'(chq.size()), 16'h0000);
      pulse(1);
      chk(16'(mode_out), 16'(MODE_RUN));
      tick(3);
      raw[0] = 16'h01F4;
      tick(4);
      chk(16'(mode_out), 16'(MODE_RUN));
      pulse(0);
      chk(16'(mode_out), 16'(MODE_RUN));
      switch_in = 1;
      repeat (6) @(posedge core_clk_in);
      #1 chk(16'(temp_hold_out), 16'h0001);
      chq.delete();
      tick(1);
      chk(16'(chq.size()), 16'h0002);
      switch_in = 0;
      zero_en_in = 1;
      chq.delete();
      tick(61);
      chk(16'(temp_hold_out), 16'h0000);
      foreach (chq[i]) n += int'(chq[i] == CH_ZERO);
      chk(16'(n > 0 && n < 3), 16'h0001);
      chk(zero_offset_value_out, 16'h0064);
      chk(current_ma_out, 16'h0190);
      wrap_up();
   end
endmodule
`default_nettype wire
